/* shared/mlq_defines.svh */
// Purpose: constants for the mass park and fault query block
// Assumes: included by its bare name from design and bench files
// Notes: mass arrives from the parser in units of 0.0001 amu
`ifndef MLQ_DEFINES_SVH
`define MLQ_DEFINES_SVH

// widths
`define MLQ_MASS_W 22
`define MLQ_STEP_W 17
`define MLQ_LVL_W 16
`define MLQ_ADDR_W 4

// mass range and conversion to 1/256 amu steps
`define MLQ_MASS_MIN_E4 22'd40
`define MLQ_MASS_SCALE_E4 10000
`define MLQ_MASS_MAX_AMU 300
`define MLQ_STEP_MUL 15'd26844
`define MLQ_STEP_SHIFT 20
`define MLQ_LEVEL_SHIFT 8

// summary status bits
`define MLQ_STAT_COMM 0
`define MLQ_STAT_MULT 3
`define MLQ_STAT_DET 5

// fault byte bits
`define MLQ_COMM_BAD_PARAM 2
`define MLQ_MULT_ABSENT 7

// detector configuration forced while the check runs
`define MLQ_DET_TEST_CFG 8'h80

// register indices on the software port
`define MLQ_REG_STATUS 4'h0
`define MLQ_REG_COMM 4'h1
`define MLQ_REG_DET 4'h2
`define MLQ_REG_FIL 4'h3
`define MLQ_REG_MULT 4'h4
`define MLQ_REG_STEP_LO 4'h5
`define MLQ_REG_STEP_HI 4'h6
`define MLQ_REG_DET_CFG 4'h7
`define MLQ_REG_STATE 4'h8

// ascii characters and decimal digit weights
`define MLQ_ASCII_ZERO 8'h30
`define MLQ_ASCII_LF 8'h0a
`define MLQ_ASCII_CR 8'h0d
`define MLQ_DEC_100 8'd100
`define MLQ_DEC_10 8'd10

`endif

/* shared/mlq_pkg.sv */
// Purpose: types shared by the mass park and fault query block
// Assumes: the command parser delivers one decoded command code
// Notes: numeric constants live in mlq_defines.svh
package mlq_pkg;

	// decoded command codes from the serial parser
	typedef enum logic [2:0] {
		MLQ_MASS_PARK_COMMAND = 3'h0,
		MLQ_COMM_FAULT_QUERY = 3'h1,
		MLQ_DETECTOR_FAULT_QUERY = 3'h2,
		MLQ_FILAMENT_FAULT_QUERY = 3'h3,
		MLQ_MULTIPLIER_FAULT_QUERY = 3'h4,
		MLQ_STATUS_QUERY = 3'h5
	} mlq_cmd_e;

	// command handler states
	typedef enum logic [2:0] {
		MLQ_ST_IDLE = 3'h0,
		MLQ_ST_CALC = 3'h1,
		MLQ_ST_STAB = 3'h2,
		MLQ_ST_DET_WAIT = 3'h3,
		MLQ_ST_SEND = 3'h4
	} mlq_state_e;

endpackage

/* src/mlq_byte_tx.sv */
// Purpose: sends one byte as unsigned decimal ascii plus terminator
// Assumes: tx sink takes a character when tx_valid and tx_ready are high
// Notes: one byte at a time; start is ignored while busy
`timescale 1ns/10ps
`include "mlq_defines.svh"

module mlq_byte_tx (
	input wire logic sys_clk, // 200 MHz clock
	input wire logic sys_rst, // async reset, active high
	input wire logic start, // pulse: format and send value
	input wire logic [7:0] value, // byte to send
	input wire logic crlf, // 1: lf then cr, 0: lf only
	output logic busy, // characters still queued
	output logic done, // pulse: last character taken
	output logic [7:0] tx_data, // character to the serial sender
	output logic tx_valid, // character stands
	input wire logic tx_ready // sender takes the character
);
	import mlq_pkg::*;

	logic [39:0] buf_q, buf_d;
	logic [2:0] left_q, left_d;
	logic done_q, done_d;
	logic valid_q, valid_d;

	// digits with no leading zeros, then the terminator, first char on top
	function automatic logic [39:0] build(input logic [7:0] v, input logic cr);
		logic [7:0] h, t, u;
		logic [39:0] b;
		h = v / `MLQ_DEC_100 + `MLQ_ASCII_ZERO;
		t = (v % `MLQ_DEC_100) / `MLQ_DEC_10 + `MLQ_ASCII_ZERO;
		u = v % `MLQ_DEC_10 + `MLQ_ASCII_ZERO;
		if (v >= `MLQ_DEC_100)
			b = {h, t, u, `MLQ_ASCII_LF, `MLQ_ASCII_CR};
		else if (v >= `MLQ_DEC_10)
			b = {t, u, `MLQ_ASCII_LF, `MLQ_ASCII_CR, 8'h00};
		else
			b = {u, `MLQ_ASCII_LF, `MLQ_ASCII_CR, 8'h00, 8'h00};
		return b;
	endfunction

	function automatic logic [2:0] count(input logic [7:0] v, input logic cr);
		logic [2:0] n;
		n = (v >= `MLQ_DEC_100) ? 3'h4 : (v >= `MLQ_DEC_10) ? 3'h3 : 3'h2;
		return cr ? n + 3'h1 : n;
	endfunction

	// shift one character out per handshake
	always_comb
	begin
		buf_d = buf_q;
		left_d = left_q;
		done_d = 1'b0;
		if (left_q != 3'h0)
		begin
			if (tx_ready)
			begin
				buf_d = {buf_q[31:0], 8'h00};
				left_d = left_q - 3'h1;
				done_d = (left_q == 3'h1);
			end
		end
		else if (start)
		begin
			buf_d = build(value, crlf);
			left_d = count(value, crlf);
		end
		// registered so the valid pin comes straight from a flop
		valid_d = (left_d != 3'h0);
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			buf_q <= '0;
			left_q <= '0;
			done_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			buf_q <= buf_d;
			left_q <= left_d;
			done_q <= done_d;
			valid_q <= valid_d;
		end
	end

	assign tx_data = buf_q[39:32];
	assign tx_valid = valid_q;
	assign busy = (left_q != 3'h0);
	assign done = done_q;

endmodule // mlq_byte_tx

/* src/mlq_top.sv */
// Purpose: mass park command and fault byte queries of the analyser head
// Assumes: parser hands over decoded commands; tx sink sends characters
// Notes: one command at a time, taken while cmd_ready is high and in the first cycle after reset, when cmd_ready is still low
`timescale 1ns/10ps
`include "mlq_defines.svh"

module mlq_top #(
	parameter int unsigned MASS_MAX_AMU = `MLQ_MASS_MAX_AMU // variant: 100, 200 or 300
) (
	input wire logic sys_clk, // 200 MHz clock
	input wire logic sys_rst, // async reset, active high
	input wire logic cmd_valid, // pulse: decoded command stands
	input wire mlq_pkg::mlq_cmd_e cmd_code, // which command
	input wire logic cmd_has_param, // a parameter followed the name
	input wire logic cmd_is_query, // parameter was a question mark
	input wire logic cmd_is_number, // parameter parsed as a number
	input wire logic [`MLQ_MASS_W-1:0] cmd_mass, // mass in 0.0001 amu
	output logic cmd_ready, // handler can take a command
	input wire logic [`MLQ_LVL_W-1:0] tune_rf_slope, // stored rf slope
	input wire logic [`MLQ_LVL_W-1:0] tune_rf_offset, // stored rf offset
	input wire logic [`MLQ_LVL_W-1:0] tune_dc_slope, // stored dc slope
	input wire logic [`MLQ_LVL_W-1:0] tune_dc_offset, // stored dc offset
	output logic filter_on, // filter drive enabled
	output logic [`MLQ_LVL_W-1:0] rf_level, // rf drive setting
	output logic [`MLQ_LVL_W-1:0] dc_level, // dc drive setting
	output logic stab_active, // drive stabilisation loop running
	output logic [7:0] det_cfg, // detector configuration
	output logic det_check_start, // pulse: run electrometer check
	input wire logic det_check_done, // pulse: check finished
	input wire logic [7:0] det_check_result, // fault bits from the check
	input wire logic [7:0] comm_fault_set, // pulses: link fault bits
	input wire logic fil_monitor_wr, // pulse: monitor writes byte
	input wire logic [7:0] fil_monitor_val, // value from the monitor
	input wire logic fil_emitting, // filament is emitting
	input wire logic fil_emission_ok, // pulse: clean emission reached
	input wire logic [7:0] mult_fault_set, // pulses: multiplier fault bits
	input wire logic mult_fitted_pin, // pin: electron_multiplier fitted
	output logic [7:0] tx_data, // character to serial sender
	output logic tx_valid, // character stands
	input wire logic tx_ready, // sender takes the character
	input wire logic [`MLQ_ADDR_W-1:0] reg_addr, // register index
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata // read data, cycle after strobe
);
	import mlq_pkg::*;

	localparam logic [`MLQ_MASS_W-1:0] MASS_MAX_E4 =
		`MLQ_MASS_W'(MASS_MAX_AMU * `MLQ_MASS_SCALE_E4);

	mlq_state_e state_q, state_d;
	mlq_cmd_e pend_q, pend_d;
	logic cmd_ready_q, cmd_ready_d;
	logic filter_on_q, filter_on_d;
	logic stab_q, stab_d;
	logic [`MLQ_LVL_W-1:0] rf_q, rf_d, dc_q, dc_d;
	logic [`MLQ_STEP_W-1:0] steps_q, steps_d;
	logic [7:0] det_cfg_q, det_cfg_d, det_save_q, det_save_d;
	logic det_start_q, det_start_d;
	logic tx_start_q, tx_start_d, tx_crlf_q, tx_crlf_d;
	logic [7:0] tx_val_q, tx_val_d;
	logic [7:0] comm_q, comm_d, det_q, det_d, fil_q, fil_d, mult_q, mult_d;
	logic [7:0] status_q, status_d;
	logic fit_s1_q, fit_s2_q, fit_s3_q, fitted_q, fitted_d;
	logic [7:0] det_sw_q, det_sw_d, rdata_q, rdata_d;
	logic tx_done;

	// mass in 0.0001 amu to 1/256 amu steps, multiply by 256/10000 in Q20
	function automatic logic [`MLQ_STEP_W-1:0] to_steps(input logic [`MLQ_MASS_W-1:0] m);
		logic [36:0] p;
		p = m * `MLQ_STEP_MUL;
		return p[`MLQ_STEP_SHIFT +: `MLQ_STEP_W];
	endfunction

	// linear drive law shared by rf and dc
	function automatic logic [`MLQ_LVL_W-1:0] calc_level(input logic [`MLQ_LVL_W-1:0] slope,
		input logic [`MLQ_LVL_W-1:0] offset, input logic [`MLQ_STEP_W-1:0] st);
		logic [32:0] p;
		p = slope * st;
		return p[`MLQ_LEVEL_SHIFT +: `MLQ_LVL_W] + offset;
	endfunction

	// queries take only a question mark
	function automatic logic query_bad(input logic has, input logic isq);
		return !has || !isq;
	endfunction

	// fitted pin: three stages, a change counts once stages two and three agree
	always_comb
	begin
		fitted_d = fitted_q;
		if (fit_s2_q == fit_s3_q)
			fitted_d = fit_s3_q;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fit_s1_q <= 1'b0;
			fit_s2_q <= 1'b0;
			fit_s3_q <= 1'b0;
			fitted_q <= 1'b0;
		end
		else
		begin
			fit_s1_q <= mult_fitted_pin;
			fit_s2_q <= fit_s1_q;
			fit_s3_q <= fit_s2_q;
			fitted_q <= fitted_d;
		end
	end

	// command sequencer and fault bytes; hardware sets win over query clears
	always_comb
	begin
		state_d = state_q;
		pend_d = pend_q;
		filter_on_d = filter_on_q;
		stab_d = stab_q;
		rf_d = rf_q;
		dc_d = dc_q;
		steps_d = steps_q;
		det_cfg_d = det_cfg_q;
		det_save_d = det_save_q;
		det_start_d = 1'b0;
		tx_start_d = 1'b0;
		tx_crlf_d = tx_crlf_q;
		tx_val_d = tx_val_q;
		det_d = det_q;
		comm_d = comm_q | comm_fault_set;
		mult_d = mult_q | mult_fault_set;
		status_d = status_q;
		if (|comm_fault_set)
			status_d[`MLQ_STAT_COMM] = 1'b1;
		if (|mult_fault_set)
			status_d[`MLQ_STAT_MULT] = 1'b1;
		// only monitor writes and the emission-ok clear touch the filament byte, queries never do
		fil_d = fil_q;
		if (fil_emitting && fil_monitor_wr)
			fil_d = fil_monitor_val;
		else if (fil_emission_ok)
			fil_d = 8'h00;
		// idle follows the software detector setting
		if (state_q == MLQ_ST_IDLE || state_q == MLQ_ST_STAB)
			det_cfg_d = det_sw_q;
		case (state_q)
			MLQ_ST_IDLE, MLQ_ST_STAB:
			begin
				if (cmd_valid)
				begin
					stab_d = 1'b0;
					state_d = MLQ_ST_IDLE;
					pend_d = cmd_code;
					case (cmd_code)
						MLQ_MASS_PARK_COMMAND:
						begin
							if (!cmd_has_param || !cmd_is_number || cmd_is_query ||
								cmd_mass > MASS_MAX_E4 ||
								(cmd_mass != '0 && cmd_mass < `MLQ_MASS_MIN_E4))
							begin
								comm_d[`MLQ_COMM_BAD_PARAM] = 1'b1;
								status_d[`MLQ_STAT_COMM] = 1'b1;
							end
							else if (cmd_mass == '0)
							begin
								filter_on_d = 1'b0;
								rf_d = '0;
								dc_d = '0;
							end
							else
							begin
								steps_d = to_steps(cmd_mass);
								state_d = MLQ_ST_CALC;
							end
						end
						MLQ_DETECTOR_FAULT_QUERY:
						begin
							if (query_bad(cmd_has_param, cmd_is_query))
							begin
								comm_d[`MLQ_COMM_BAD_PARAM] = 1'b1;
								status_d[`MLQ_STAT_COMM] = 1'b1;
							end
							else
							begin
								det_save_d = det_sw_q;
								det_cfg_d = `MLQ_DET_TEST_CFG;
								det_start_d = 1'b1;
								state_d = MLQ_ST_DET_WAIT;
							end
						end
						MLQ_COMM_FAULT_QUERY, MLQ_FILAMENT_FAULT_QUERY,
						MLQ_MULTIPLIER_FAULT_QUERY, MLQ_STATUS_QUERY:
						begin
							if (query_bad(cmd_has_param, cmd_is_query))
							begin
								comm_d[`MLQ_COMM_BAD_PARAM] = 1'b1;
								status_d[`MLQ_STAT_COMM] = 1'b1;
							end
							else
							begin
								tx_start_d = 1'b1;
								state_d = MLQ_ST_SEND;
								tx_crlf_d = 1'b1;
								tx_val_d = comm_q;
								if (cmd_code == MLQ_FILAMENT_FAULT_QUERY)
								begin
									tx_val_d = fil_q;
									tx_crlf_d = 1'b0;
								end
								else if (cmd_code == MLQ_STATUS_QUERY)
								begin
									tx_val_d = status_q;
									tx_crlf_d = 1'b0;
								end
								else if (cmd_code == MLQ_MULTIPLIER_FAULT_QUERY)
								begin
									tx_val_d = mult_q;
									tx_val_d[`MLQ_MULT_ABSENT] =
										mult_q[`MLQ_MULT_ABSENT] | !fitted_q;
								end
							end
						end
						default:
						begin
							pend_d = pend_q; // unknown codes only stop stabilisation
						end
					endcase
				end
			end
			MLQ_ST_CALC:
			begin
				// levels come from the tuning inputs as they stand now
				rf_d = calc_level(tune_rf_slope, tune_rf_offset, steps_q);
				dc_d = calc_level(tune_dc_slope, tune_dc_offset, steps_q);
				filter_on_d = 1'b1;
				stab_d = 1'b1;
				state_d = MLQ_ST_STAB;
			end
			MLQ_ST_DET_WAIT:
			begin
				if (det_check_done)
				begin
					det_d = det_check_result;
					status_d[`MLQ_STAT_DET] = |det_check_result;
					det_cfg_d = det_save_q;
					tx_val_d = det_check_result;
					tx_crlf_d = 1'b1;
					tx_start_d = 1'b1;
					state_d = MLQ_ST_SEND;
				end
			end
			MLQ_ST_SEND:
			begin
				if (tx_done)
				begin
					state_d = MLQ_ST_IDLE;
					if (pend_q == MLQ_COMM_FAULT_QUERY)
					begin
						comm_d = comm_fault_set;
						status_d[`MLQ_STAT_COMM] = |comm_fault_set;
					end
					else if (pend_q == MLQ_MULTIPLIER_FAULT_QUERY)
					begin
						mult_d = mult_fault_set;
						status_d[`MLQ_STAT_MULT] = |mult_fault_set;
					end
				end
			end
			default:
			begin
				state_d = MLQ_ST_IDLE;
			end
		endcase
		cmd_ready_d = (state_d == MLQ_ST_IDLE) || (state_d == MLQ_ST_STAB);
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= MLQ_ST_IDLE;
			pend_q <= MLQ_MASS_PARK_COMMAND;
			cmd_ready_q <= 1'b0;
			filter_on_q <= 1'b0;
			stab_q <= 1'b0;
			rf_q <= '0;
			dc_q <= '0;
			steps_q <= '0;
			det_cfg_q <= '0;
			det_save_q <= '0;
			det_start_q <= 1'b0;
			tx_start_q <= 1'b0;
			tx_crlf_q <= 1'b0;
			tx_val_q <= '0;
			comm_q <= '0;
			det_q <= '0;
			fil_q <= '0;
			mult_q <= '0;
			status_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			pend_q <= pend_d;
			cmd_ready_q <= cmd_ready_d;
			filter_on_q <= filter_on_d;
			stab_q <= stab_d;
			rf_q <= rf_d;
			dc_q <= dc_d;
			steps_q <= steps_d;
			det_cfg_q <= det_cfg_d;
			det_save_q <= det_save_d;
			det_start_q <= det_start_d;
			tx_start_q <= tx_start_d;
			tx_crlf_q <= tx_crlf_d;
			tx_val_q <= tx_val_d;
			comm_q <= comm_d;
			det_q <= det_d;
			fil_q <= fil_d;
			mult_q <= mult_d;
			status_q <= status_d;
		end
	end

	// character sender; a full reply is never overlapped by a new one
	mlq_byte_tx u_tx (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(tx_start_q),
		.value(tx_val_q),
		.crlf(tx_crlf_q),
		.busy(),
		.done(tx_done),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready)
	);

	// software port: reads have no side effects, unmapped reads give zero
	always_comb
	begin
		det_sw_d = det_sw_q;
		rdata_d = 8'h00;
		// a write during the detector check is dropped so restore stays exact
		if (reg_wr && reg_addr == `MLQ_REG_DET_CFG && state_q != MLQ_ST_DET_WAIT)
			det_sw_d = reg_wdata;
		if (reg_rd)
		begin
			case (reg_addr)
				`MLQ_REG_STATUS: rdata_d = status_q;
				`MLQ_REG_COMM: rdata_d = comm_q;
				`MLQ_REG_DET: rdata_d = det_q;
				`MLQ_REG_FIL: rdata_d = fil_q;
				`MLQ_REG_MULT: rdata_d = mult_q;
				`MLQ_REG_STEP_LO: rdata_d = steps_q[7:0];
				`MLQ_REG_STEP_HI: rdata_d = steps_q[15:8];
				`MLQ_REG_DET_CFG: rdata_d = det_sw_q;
				`MLQ_REG_STATE: rdata_d = {4'h0, fitted_q, state_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			det_sw_q <= '0;
			rdata_q <= '0;
		end
		else
		begin
			det_sw_q <= det_sw_d;
			rdata_q <= rdata_d;
		end
	end

	assign cmd_ready = cmd_ready_q;
	assign filter_on = filter_on_q;
	assign rf_level = rf_q;
	assign dc_level = dc_q;
	assign stab_active = stab_q;
	assign det_cfg = det_cfg_q;
	assign det_check_start = det_start_q;
	assign reg_rdata = rdata_q;

endmodule // mlq_top

/* tb/mlq_chk.sv */
// Purpose: port-level checker for the mass park and fault query block
// Assumes: one clock domain, async active-high reset
// Notes: antecedents key on commands that the handler really takes
`timescale 1ns/10ps
module mlq_chk #(
	parameter int unsigned MASS_MAX_AMU = 300 // variant upper mass in amu
) (
	input wire logic sys_clk, // block clock
	input wire logic sys_rst, // async reset, active high
	input wire logic cmd_valid, // command stands
	input wire mlq_pkg::mlq_cmd_e cmd_code, // which command
	input wire logic cmd_has_param, // a parameter followed
	input wire logic cmd_is_query, // parameter was a question mark
	input wire logic cmd_is_number, // parameter was numeric
	input wire logic [21:0] cmd_mass, // mass in 0.0001 amu
	input wire logic cmd_ready, // handler can take a command
	input wire logic filter_on, // filter drive enabled
	input wire logic [15:0] rf_level, // rf drive setting
	input wire logic [15:0] dc_level, // dc drive setting
	input wire logic stab_active, // stabilisation running
	input wire logic det_check_start, // detector check pulse
	input wire logic [7:0] tx_data, // outgoing character
	input wire logic tx_valid, // character stands
	input wire logic tx_ready // sink takes it
);
	import mlq_pkg::*;
	localparam logic [21:0] MAX_E4 = 22'(MASS_MAX_AMU * 10000);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// decoded views of a taken command
	wire take = cmd_valid & cmd_ready;
	wire park = take & (cmd_code == MLQ_MASS_PARK_COMMAND) & cmd_has_param & cmd_is_number
		& !cmd_is_query;
	wire park_ok = park & (cmd_mass >= 22'd40) & (cmd_mass <= MAX_E4);
	wire qry = take & cmd_has_param & cmd_is_query;
	// status query is refused bare like the others, but it is left out here
	wire q_bare = take & !cmd_has_param & (cmd_code != MLQ_MASS_PARK_COMMAND)
		& (cmd_code != MLQ_STATUS_QUERY);

	a_park_apply: assert property (park_ok |-> ##2 filter_on && stab_active && cmd_ready)
		else $error("park did not drive the filter");
	a_park_zero_off: assert property (park && cmd_mass == 22'h0 |=>
		!filter_on && rf_level == 16'h0 && dc_level == 16'h0)
		else $error("park at zero left drive on");
	a_park_range_rej: assert property (park && cmd_mass > MAX_E4 |=>
		cmd_ready && $stable(filter_on) && $stable(rf_level))
		else $error("out of range park changed the drive");
	a_park_no_echo: assert property (park_ok |=> !tx_valid [*4])
		else $error("park produced a reply");
	a_stab_stop: assert property (take |=> !stab_active)
		else $error("stabilisation kept running after a command");
	a_stab_keep: assert property (stab_active && !take |=> stab_active)
		else $error("stabilisation stopped without a command");
	a_bare_query: assert property (q_bare |=> cmd_ready && !tx_valid)
		else $error("query without parameter was not refused");
	a_det_check: assert property (qry && cmd_code == MLQ_DETECTOR_FAULT_QUERY |=> det_check_start)
		else $error("detector query did not start a check");
	a_comm_reply: assert property (qry && cmd_code == MLQ_COMM_FAULT_QUERY |-> ##2 tx_valid)
		else $error("comm query reply missing");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("character dropped before taken");
endmodule // mlq_chk

bind mlq_top mlq_chk #(.MASS_MAX_AMU(MASS_MAX_AMU)) chk_u (.sys_clk, .sys_rst, .cmd_valid,
	.cmd_code, .cmd_has_param, .cmd_is_query, .cmd_is_number, .cmd_mass, .cmd_ready,
	.filter_on, .rf_level, .dc_level, .stab_active, .det_check_start, .tx_data, .tx_valid,
	.tx_ready);

/* tb/mlq_host_model.sv */
// Purpose: serial sink of the host and the electrometer check electronics
// Assumes: a character is taken on an edge with tx_valid and tx_ready high
// Notes: stall halves the take rate to exercise the hold of tx_data
`timescale 1ns/10ps
module mlq_host_model #(
	parameter int DET_DELAY = 20 // cycles the check needs
) (
	input wire logic sys_clk, // block clock
	input wire logic sys_rst, // async reset, active high
	input wire logic [7:0] tx_data, // character from the block
	input wire logic tx_valid, // character stands
	output logic tx_ready, // sink takes the character
	input wire logic stall, // 1: take only on alternate cycles
	input wire logic det_check_start, // pulse: run check
	input wire logic [7:0] det_value, // result of the next check
	output logic det_check_done, // pulse: check finished
	output logic [7:0] det_check_result // valid only with done
);
	logic [7:0] rx_q[$];
	int det_cnt;
	// sink and check timer; result toggles outside done so it is never mistaken
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_ready <= 1'b0;
			det_cnt <= 0;
			det_check_done <= 1'b0;
			det_check_result <= 8'h00;
		end
		else
		begin
			if (tx_valid && tx_ready)
				rx_q.push_back(tx_data);
			tx_ready <= stall ? !tx_ready : 1'b1;
			det_check_done <= (det_cnt == 1);
			det_check_result <= (det_cnt == 1) ? det_value : ~det_check_result;
			if (det_check_start)
				det_cnt <= DET_DELAY;
			else if (det_cnt > 0)
				det_cnt <= det_cnt - 1;
		end
	end
endmodule // mlq_host_model

/* tb/tb_top.sv */
// Purpose: self-checking bench for the mass park and fault query block
// Assumes: smallest mass variant so the range edge is cheap to reach
// Notes: expected replies are built from the byte values, not the design
`timescale 1ns/10ps
`include "mlq_defines.svh"
`define chk(a, b, m) \
	begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected at %0t: %s", $time, m); end end
module tb_top;
	import mlq_pkg::*;
	localparam int unsigned MAXA = 100;
	logic sys_clk, sys_rst, cmd_valid, cmd_has_param, cmd_is_query, cmd_is_number, cmd_ready;
	mlq_cmd_e cmd_code;
	logic [21:0] cmd_mass, last_m;
	logic [15:0] tune_rf_slope, tune_rf_offset, tune_dc_slope, tune_dc_offset, rf_level, dc_level;
	logic filter_on, stab_active, det_check_start, det_check_done, fil_monitor_wr, fil_emitting;
	logic fil_emission_ok, mult_fitted_pin, tx_valid, tx_ready, reg_wr, reg_rd, stall;
	logic [7:0] det_cfg, det_check_result, comm_fault_set, fil_monitor_val, mult_fault_set;
	logic [7:0] tx_data, reg_wdata, reg_rdata, det_value;
	logic [3:0] reg_addr;
	int fail_count, checks_done, cycles;

	mlq_top #(.MASS_MAX_AMU(MAXA)) dut_u (.sys_clk, .sys_rst, .cmd_valid, .cmd_code,
		.cmd_has_param, .cmd_is_query, .cmd_is_number, .cmd_mass, .cmd_ready, .tune_rf_slope,
		.tune_rf_offset, .tune_dc_slope, .tune_dc_offset, .filter_on, .rf_level, .dc_level,
		.stab_active, .det_cfg, .det_check_start, .det_check_done, .det_check_result,
		.comm_fault_set, .fil_monitor_wr, .fil_monitor_val, .fil_emitting, .fil_emission_ok,
		.mult_fault_set, .mult_fitted_pin, .tx_data, .tx_valid, .tx_ready, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	mlq_host_model host_u (.sys_clk, .sys_rst, .tx_data, .tx_valid, .tx_ready, .stall,
		.det_check_start, .det_value, .det_check_done, .det_check_result);

	// 200 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under 3000 cycles
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			$display("unexpected at %0t: run did not finish", $time);
			stop_test;
		end
	end

	function automatic logic [15:0] lvl(logic [15:0] s, logic [15:0] o, logic [21:0] m);
		logic [63:0] st;
		st = (64'(m) * 64'd26844) >> 20;
		return 16'(((64'(s) * st) >> 8) + 64'(o));
	endfunction

	// a command waits for ready, then stands for exactly one edge
	task automatic cmd(mlq_cmd_e c, logic h, logic q, logic n, logic [21:0] m);
		int i;
		@(posedge sys_clk);
		for (i = 0; i < 500 && cmd_ready !== 1'b1; i++)
			@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_has_param <= h;
		cmd_is_query <= q;
		cmd_is_number <= n;
		cmd_mass <= m;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
	endtask

	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`chk(reg_rdata, e, "register read")
	endtask

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// good park: drive levels two edges after the command is taken
	task automatic park(logic [21:0] m);
		logic [16:0] st;
		st = 17'((64'(m) * 64'd26844) >> 20);
		cmd(MLQ_MASS_PARK_COMMAND, 1'b1, 1'b0, 1'b1, m);
		repeat (2) @(posedge sys_clk);
		#1;
		last_m = m;
		`chk(filter_on, 1'b1, "filter not on")
		`chk(stab_active, 1'b1, "no stabilisation")
		`chk(rf_level, lvl(tune_rf_slope, tune_rf_offset, m), "rf level")
		`chk(dc_level, lvl(tune_dc_slope, tune_dc_offset, m), "dc level")
		rd(4'h5, st[7:0]);
		rd(4'h6, st[15:8]);
	endtask

	// query and compare the unpadded decimal reply character by character
	task automatic reply(mlq_cmd_e c, logic [7:0] v, logic crlf);
		logic [7:0] e[$];
		int i;
		if (v >= 8'd100)
			e.push_back(8'h30 + v / 8'd100);
		if (v >= 8'd10)
			e.push_back(8'h30 + v / 8'd10 % 8'd10);
		e.push_back(8'h30 + v % 8'd10);
		e.push_back(8'h0a);
		if (crlf)
			e.push_back(8'h0d);
		host_u.rx_q.delete();
		cmd(c, 1'b1, 1'b1, 1'b0, 22'h0);
		for (i = 0; i < 400 && host_u.rx_q.size() < e.size(); i++)
			@(posedge sys_clk);
		if (c == MLQ_DETECTOR_FAULT_QUERY)
			`chk(det_cfg, 8'h3c, "detector setup lost in reply")
		repeat (6) @(posedge sys_clk);
		`chk(host_u.rx_q.size(), e.size(), "reply length")
		foreach (e[k])
			if (k < host_u.rx_q.size())
				`chk(host_u.rx_q[k], e[k], "reply character")
	endtask

	initial
	begin
		{cmd_valid, cmd_has_param, cmd_is_query, cmd_is_number, reg_wr, reg_rd, stall} = 7'h0;
		{fil_monitor_wr, fil_emitting, fil_emission_ok, mult_fitted_pin} = 4'h0;
		{comm_fault_set, fil_monitor_val, mult_fault_set, reg_wdata, det_value} = 40'h0;
		{cmd_mass, last_m, reg_addr, cycles} = 0;
		cmd_code = MLQ_MASS_PARK_COMMAND;
		tune_rf_slope = 16'h0200;
		tune_rf_offset = 16'h0010;
		tune_dc_slope = 16'h0040;
		tune_dc_offset = 16'h0003;
		sys_rst = 1'b1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 5; a++)
			rd(4'(a), 8'h00);
		rd(4'hf, 8'h00);
		park(22'd50000);
		tune_rf_slope <= 16'hfff1;
		tune_dc_offset <= 16'h0100;
		park(22'd40);
		park(22'(MAXA * 10000));
		cmd(MLQ_MASS_PARK_COMMAND, 1'b1, 1'b0, 1'b1, 22'(MAXA * 10000 + 1));
		cmd(MLQ_MASS_PARK_COMMAND, 1'b0, 1'b0, 1'b0, 22'h0);
		cmd(MLQ_MASS_PARK_COMMAND, 1'b1, 1'b0, 1'b0, 22'd50000);
		cmd(MLQ_MASS_PARK_COMMAND, 1'b1, 1'b0, 1'b1, 22'd39);
		`chk(rf_level, lvl(tune_rf_slope, tune_rf_offset, last_m), "drive changed")
		rd(4'h1, 8'h04);
		rd(4'h0, 8'h01);
		reply(MLQ_COMM_FAULT_QUERY, 8'h04, 1'b1);
		`chk(stab_active, 1'b0, "stabilisation survived a command")
		rd(4'h1, 8'h00);
		rd(4'h0, 8'h00);
		for (int c = 1; c < 5; c++)
		begin
			cmd(mlq_cmd_e'(3'(c)), 1'b0, 1'b0, 1'b0, 22'h0);
			cmd(mlq_cmd_e'(3'(c)), 1'b1, 1'b0, 1'b1, 22'h0);
		end
		reply(MLQ_COMM_FAULT_QUERY, 8'h04, 1'b1);
		wr(4'h7, 8'h3c);
		rd(4'h7, 8'h3c);
		det_value <= 8'h05;
		reply(MLQ_DETECTOR_FAULT_QUERY, 8'h05, 1'b1);
		rd(4'h0, 8'h20);
		rd(4'h2, 8'h05);
		`chk(det_cfg, 8'h3c, "detector setup not restored")
		det_value <= 8'h00;
		reply(MLQ_DETECTOR_FAULT_QUERY, 8'h00, 1'b1);
		rd(4'h0, 8'h00);
		fil_emitting <= 1'b1;
		fil_monitor_val <= 8'hc8;
		wr(4'hf, 8'h55);
		@(posedge sys_clk);
		fil_monitor_wr <= 1'b1;
		@(posedge sys_clk);
		fil_monitor_wr <= 1'b0;
		fil_emitting <= 1'b0;
		fil_monitor_val <= 8'h01;
		@(posedge sys_clk);
		fil_monitor_wr <= 1'b1;
		@(posedge sys_clk);
		fil_monitor_wr <= 1'b0;
		reply(MLQ_FILAMENT_FAULT_QUERY, 8'hc8, 1'b0);
		rd(4'h3, 8'hc8);
		fil_emission_ok <= 1'b1;
		@(posedge sys_clk);
		fil_emission_ok <= 1'b0;
		rd(4'h3, 8'h00);
		stall <= 1'b1;
		mult_fault_set <= 8'h03;
		@(posedge sys_clk);
		mult_fault_set <= 8'h00;
		rd(4'h0, 8'h08);
		reply(MLQ_MULTIPLIER_FAULT_QUERY, 8'h83, 1'b1);
		rd(4'h4, 8'h00);
		rd(4'h0, 8'h00);
		mult_fitted_pin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rd(4'h8, 8'h08);
		mult_fault_set <= 8'h01;
		@(posedge sys_clk);
		mult_fault_set <= 8'h00;
		reply(MLQ_MULTIPLIER_FAULT_QUERY, 8'h01, 1'b1);
		stall <= 1'b0;
		comm_fault_set <= 8'h01;
		@(posedge sys_clk);
		comm_fault_set <= 8'h00;
		reply(MLQ_STATUS_QUERY, 8'h01, 1'b0);
		cmd(MLQ_MASS_PARK_COMMAND, 1'b1, 1'b0, 1'b1, 22'h0);
		@(posedge sys_clk);
		#1;
		`chk({filter_on, rf_level, dc_level}, 33'h0, "drive not off")
		stop_test;
	end
endmodule // tb_top
